/* File: rtl/gtc_top.sv */
// Port control register and graphics translation cache control
`timescale 1ns/1ps
module gtc_top
(
   input  wire logic                        MCLK,
   input  wire logic                        RST,
   input  wire gtc_pkg::gtc_cfg_req_t       CFG_REQ,
   output logic                             CFG_DONE,
   output logic [31:0]                      CFG_RDATA,
   input  wire logic [2:0]                  RATE_RAW,
   output logic [2:0]                       RATE_READ,
   input  wire logic                        WB_DIRTY,
   output logic                             WB_FLUSH_REQ,
   input  wire logic                        XL_REQ,
   input  wire logic                        XL_APERTURE,
   input  wire logic [gtc_pkg::TAG_W-1:0]   XL_TAG,
   output logic                             XL_HIT,
   output logic [gtc_pkg::PFN_W-1:0]        XL_PFN,
   output logic                             XL_FETCH,
   output logic [gtc_pkg::TAG_W-1:0]        XL_FETCH_TAG,
   input  wire logic                        FETCH_DONE,
   input  wire gtc_pkg::gtc_entry_t         FETCH_ENTRY,
   output logic                             CACHE_ENABLE
);

   typedef enum {GTC_IDLE, GTC_DRAIN} gtc_state_t;

   // ----------------------------------------------------------------
   // Control register and config write completion
   // ----------------------------------------------------------------
   logic        cache_en_q, cache_en_d;
   logic        ovr_q, ovr_d;
   logic        pend_en_q, pend_en_d;
   logic        done_q, done_d;
   logic [31:0] rdata_q, rdata_d;
   gtc_state_t  st_q, st_d;
   logic        hit_ctrl;
   logic        en_change;

   assign hit_ctrl  = CFG_REQ.addr == gtc_pkg::PORT_CTRL_OFS;
   assign en_change = CFG_REQ.wr && hit_ctrl && CFG_REQ.be[0]
                      && (CFG_REQ.wdata[gtc_pkg::CACHE_EN_BIT] != cache_en_q);

   // Next values of the register; an enable change waits for the buffer
   always_comb
   begin
      cache_en_d = cache_en_q;
      ovr_d      = ovr_q;
      pend_en_d  = pend_en_q;
      done_d     = 1'b0;
      rdata_d    = rdata_q;
      st_d       = st_q;
      unique case (st_q)
         GTC_IDLE:
         begin
            if (CFG_REQ.rd)
            begin
               rdata_d = 32'h0000_0000;
               if (hit_ctrl)
               begin
                  rdata_d[gtc_pkg::CACHE_EN_BIT] = cache_en_q;
                  rdata_d[gtc_pkg::RATE_OVR_BIT] = ovr_q;
               end
               done_d = 1'b1;
            end
            else if (en_change)
            begin
               // Override bit lands now, enable only after the drain
               ovr_d     = CFG_REQ.wdata[gtc_pkg::RATE_OVR_BIT];
               pend_en_d = CFG_REQ.wdata[gtc_pkg::CACHE_EN_BIT];
               st_d      = GTC_DRAIN;
            end
            else if (CFG_REQ.wr)
            begin
               if (hit_ctrl && CFG_REQ.be[0])
                  ovr_d = CFG_REQ.wdata[gtc_pkg::RATE_OVR_BIT];
               done_d = 1'b1;
            end
         end
         GTC_DRAIN:
         begin
            if (!WB_DIRTY)
            begin
               cache_en_d = pend_en_q;
               done_d     = 1'b1;
               st_d       = GTC_IDLE;
            end
         end
      endcase
   end

   // Register stage, all zeros after reset
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         cache_en_q <= gtc_pkg::PORT_CTRL_RST[gtc_pkg::CACHE_EN_BIT];
         ovr_q      <= gtc_pkg::PORT_CTRL_RST[gtc_pkg::RATE_OVR_BIT];
         pend_en_q  <= 1'b0;
         done_q     <= 1'b0;
         rdata_q    <= gtc_pkg::PORT_CTRL_RST;
         st_q       <= GTC_IDLE;
      end
      else
      begin
         cache_en_q <= cache_en_d;
         ovr_q      <= ovr_d;
         pend_en_q  <= pend_en_d;
         done_q     <= done_d;
         rdata_q    <= rdata_d;
         st_q       <= st_d;
      end
   end

   assign CFG_DONE     = done_q;
   assign CFG_RDATA    = rdata_q;
   assign WB_FLUSH_REQ = st_q == GTC_DRAIN;
   assign CACHE_ENABLE = cache_en_q;

   // Status rate field as seen by software; 001 is the lowest mode
   assign RATE_READ = ovr_q ? gtc_pkg::RATE_LOWEST : RATE_RAW;

   // ----------------------------------------------------------------
   // Translation cache
   // ----------------------------------------------------------------
   gtc_pkg::gtc_entry_t            ent_q [gtc_pkg::ENTRIES];
   gtc_pkg::gtc_entry_t            ent_d [gtc_pkg::ENTRIES];
   logic [gtc_pkg::IDX_W-1:0]      age_q [gtc_pkg::ENTRIES];
   logic [gtc_pkg::IDX_W-1:0]      age_d [gtc_pkg::ENTRIES];
   logic                           hit;
   logic [gtc_pkg::IDX_W-1:0]      hit_idx;
   logic [gtc_pkg::IDX_W-1:0]      lru_idx;
   logic [gtc_pkg::PFN_W-1:0]      hit_pfn;
   logic                           fill;
   logic [gtc_pkg::IDX_W-1:0]      fill_idx;
   logic                           busy_q, busy_d;
   logic [gtc_pkg::TAG_W-1:0]      ftag_q, ftag_d;
   logic                           xhit_q, xhit_d;
   logic [gtc_pkg::PFN_W-1:0]      xpfn_q, xpfn_d;

   // Lookup and LRU victim search; lookup is skipped when disabled
   always_comb
   begin
      hit     = 1'b0;
      hit_idx = '0;
      hit_pfn = '0;
      lru_idx = '0;
      for (int i = 0; i < gtc_pkg::ENTRIES; i++)
      begin
         if (cache_en_q && ent_q[i].valid && ent_q[i].tag == XL_TAG)
         begin
            hit     = 1'b1;
            hit_idx = i[gtc_pkg::IDX_W-1:0];
            hit_pfn = ent_q[i].pfn;
         end
         if (age_q[i] == '1)
            lru_idx = i[gtc_pkg::IDX_W-1:0];
      end
   end

   // Fill policy: enabled stores all, disabled stores only invalid entries
   assign fill     = busy_q && FETCH_DONE
                     && (cache_en_q || !FETCH_ENTRY.valid);
   assign fill_idx = lru_idx;

   // Request sequencing, entries and age ordering
   always_comb
   begin
      busy_d = busy_q;
      ftag_d = ftag_q;
      xhit_d = 1'b0;
      xpfn_d = xpfn_q;
      ent_d  = ent_q;
      age_d  = age_q;
      if (!busy_q && XL_REQ && XL_APERTURE && hit)
      begin
         xhit_d = 1'b1;
         xpfn_d = hit_pfn;
         for (int i = 0; i < gtc_pkg::ENTRIES; i++)
            if (age_q[i] < age_q[hit_idx])
               age_d[i] = age_q[i] + 3'h1;
         age_d[hit_idx] = '0;
      end
      else if (!busy_q && XL_REQ && XL_APERTURE)
      begin
         busy_d = 1'b1;
         ftag_d = XL_TAG;
      end
      else if (busy_q && FETCH_DONE)
      begin
         busy_d = 1'b0;
         xhit_d = 1'b1;
         xpfn_d = FETCH_ENTRY.pfn;
         if (fill)
         begin
            ent_d[fill_idx] = FETCH_ENTRY;
            for (int i = 0; i < gtc_pkg::ENTRIES; i++)
               if (age_q[i] < age_q[fill_idx])
                  age_d[i] = age_q[i] + 3'h1;
            age_d[fill_idx] = '0;
         end
      end
      // Flush: clear every valid flag while disabled
      if (!cache_en_q)
         for (int i = 0; i < gtc_pkg::ENTRIES; i++)
            if (!(fill && fill_idx == i[gtc_pkg::IDX_W-1:0]))
               ent_d[i].valid = 1'b0;
   end

   // Age starts as a permutation so one entry is always least recent
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         busy_q <= 1'b0;
         ftag_q <= '0;
         xhit_q <= 1'b0;
         xpfn_q <= '0;
         for (int i = 0; i < gtc_pkg::ENTRIES; i++)
         begin
            ent_q[i] <= '0;
            age_q[i] <= i[gtc_pkg::IDX_W-1:0];
         end
      end
      else
      begin
         busy_q <= busy_d;
         ftag_q <= ftag_d;
         xhit_q <= xhit_d;
         xpfn_q <= xpfn_d;
         ent_q  <= ent_d;
         age_q  <= age_d;
      end
   end

   assign XL_HIT       = xhit_q;
   assign XL_PFN       = xpfn_q;
   assign XL_FETCH     = busy_q;
   assign XL_FETCH_TAG = ftag_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Drain steps: waiting on a dirty buffer, then the cycle it comes clean
   sequence s_drain_dirty;
      st_q == GTC_DRAIN && WB_DIRTY;
   endsequence
   sequence s_drain_clean;
      st_q == GTC_DRAIN && !WB_DIRTY;
   endsequence

   a_drain_holds_done: assert property (@(posedge MCLK) disable iff (RST)
      s_drain_dirty |=> !CFG_DONE)
      else $error("Enable write completed while buffer dirty");
   a_drain_ends_done: assert property (@(posedge MCLK) disable iff (RST)
      s_drain_clean |=> CFG_DONE && cache_en_q == $past(pend_en_q))
      else $error("Drain end did not complete write");
   a_rate_forced: assert property (@(posedge MCLK) disable iff (RST)
      ovr_q |-> RATE_READ == gtc_pkg::RATE_LOWEST)
      else $error("Override did not force rate 001");
   a_rate_passed: assert property (@(posedge MCLK) disable iff (RST)
      !ovr_q |-> RATE_READ == RATE_RAW)
      else $error("Rate altered without override");
   a_flush_clears: assert property (@(posedge MCLK) disable iff (RST)
      (!cache_en_q && !fill) |=> !ent_q[0].valid)
      else $error("Entry valid while cache disabled");
   a_no_hit_off: assert property (@(posedge MCLK) disable iff (RST)
      !cache_en_q |-> !hit)
      else $error("Lookup hit while cache disabled");
   a_miss_fetch: assert property (@(posedge MCLK) disable iff (RST)
      (!busy_q && XL_REQ && XL_APERTURE && !cache_en_q) |=> XL_FETCH)
      else $error("Aperture request did not fetch");
   a_valid_not_kept: assert property (@(posedge MCLK) disable iff (RST)
      (!cache_en_q && busy_q && FETCH_DONE && FETCH_ENTRY.valid) |-> !fill)
      else $error("Valid entry stored while disabled");
   a_invalid_kept: assert property (@(posedge MCLK) disable iff (RST)
      (busy_q && FETCH_DONE && !FETCH_ENTRY.valid) |-> fill)
      else $error("Invalid entry not stored");
   a_rsvd_zero: assert property (@(posedge MCLK) disable iff (RST)
      CFG_DONE |-> CFG_RDATA[6:1] == 6'h00 && CFG_RDATA[31:8] == 24'h0)
      else $error("Reserved bits read nonzero");

endmodule : gtc_top

/* File: rtl/gtc_pkg.sv */
// Constants and types for the port control register block
package gtc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  PORT_CTRL_OFS   = 8'hb0;
   localparam logic [31:0] PORT_CTRL_RST   = 32'h0000_0000;
   localparam int          CACHE_EN_BIT    = 7;
   localparam int          RATE_OVR_BIT    = 0;
   localparam logic [2:0]  RATE_LOWEST     = 3'h1;
   localparam int          ENTRIES         = 8;
   localparam int          IDX_W           = 3;
   localparam int          TAG_W           = 20;
   localparam int          PFN_W           = 20;

   // Configuration write/read request
   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } gtc_cfg_req_t;

   // Translation table entry returned from memory
   typedef struct packed
   {
      logic             valid;
      logic [TAG_W-1:0] tag;
      logic [PFN_W-1:0] pfn;
   } gtc_entry_t;

endpackage : gtc_pkg

/* File: bench/gtc_mem_model.sv */
// Memory-side model that answers translation table fetches
`timescale 1ns/1ps
module gtc_mem_model
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      fetch,
   input  wire logic [gtc_pkg::TAG_W-1:0] fetch_tag,
   input  wire logic                      ent_valid,
   input  wire logic [3:0]                delay,
   output gtc_pkg::gtc_entry_t            done_entry,
   output logic                           done
);
   int cnt;

   // Answer after a chosen wait; entry lines scramble outside the answer cycle
   // so a stale entry can never pass for a fresh one
   always @(posedge clk)
   begin
      if (rst || !fetch || done)
      begin
         cnt = 0;
         done <= 1'b0;
         done_entry <= rst ? '0 : ~done_entry;
      end
      else if (cnt >= int'(delay))
      begin
         done <= 1'b1;
         done_entry <= '{ent_valid, fetch_tag, fetch_tag ^ 20'h5a5a5};
      end
      else
      begin
         cnt = cnt + 1;
         done_entry <= ~done_entry;
      end
   end
endmodule : gtc_mem_model

/* File: bench/test_graphics_tlb_control.sv */
// Self-checking testbench for the port control register and translation cache
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_graphics_tlb_control;
   logic                 mclk = 1'b0;
   logic                 rst = 1'b1;
   gtc_pkg::gtc_cfg_req_t req = '0;
   gtc_pkg::gtc_entry_t  f_ent;
   logic                 done, wb_flush, xl_hit, xl_fetch, f_done, cache_en;
   logic [31:0]          rdata, r;
   logic [2:0]           rate_raw = 3'h0, rate_read;
   logic                 wb_dirty = 1'b0, xl_req = 1'b0, xl_ap = 1'b0, ent_valid = 1'b1;
   logic [19:0]          xl_tag = 20'h0, xl_pfn, xl_ftag;
   logic [3:0]           delay = 4'h0;
   logic [31:0]          reg_m = 32'h0;
   bit                   cached [int];
   int                   n_errors = 0, cmp_count = 0, cyc = 0, k;

   always #5 mclk = ~mclk;

   gtc_top u_dut (.MCLK(mclk), .RST(rst), .CFG_REQ(req), .CFG_DONE(done), .CFG_RDATA(rdata),
      .RATE_RAW(rate_raw), .RATE_READ(rate_read), .WB_DIRTY(wb_dirty), .WB_FLUSH_REQ(wb_flush),
      .XL_REQ(xl_req), .XL_APERTURE(xl_ap), .XL_TAG(xl_tag), .XL_HIT(xl_hit), .XL_PFN(xl_pfn),
      .XL_FETCH(xl_fetch), .XL_FETCH_TAG(xl_ftag), .FETCH_DONE(f_done), .FETCH_ENTRY(f_ent),
      .CACHE_ENABLE(cache_en));

   gtc_mem_model u_mem (.clk(mclk), .rst(rst), .fetch(xl_fetch), .fetch_tag(xl_ftag),
      .ent_valid(ent_valid), .delay(delay), .done_entry(f_ent), .done(f_done));

   // Config access; dirty holds the write buffer dirty for that many cycles
   task cfg(input logic wr, input logic [7:0] a, input logic [31:0] d, input int dirty);
      int i;
      @(posedge mclk);
      req <= '{wr, !wr, a, 4'h1, d};
      wb_dirty <= (dirty > 0);
      // Done stands one cycle, so look just after every edge from the taking one on
      for (i = 0; i < 60; i++)
      begin
         @(posedge mclk);
         if (i == 0) req <= '0;
         if (i == dirty) wb_dirty <= 1'b0;
         #1;
         if (done === 1'b1) break;
         if (i < dirty) `CHK(wb_flush, 1'b1)
      end
      `CHK(done, 1'b1)
      `CHK(wb_flush, 1'b0)
      if (dirty > 0) `CHK(i >= dirty, 1'b1)
      r = rdata;
      if (wr && a == 8'hb0)
      begin
         if (!d[7]) cached.delete();
         reg_m = d & 32'h0000_0081;
      end
      if (!wr) `CHK(r, (a == 8'hb0) ? reg_m : 32'h0)
      `CHK(cache_en, reg_m[7])
   endtask : cfg

   // Translation request; a miss must go to the table before answering
   task xl(input logic [19:0] t);
      int i;
      logic f;
      f = 1'b0;
      @(posedge mclk);
      xl_req <= 1'b1;
      xl_ap <= 1'b1;
      xl_tag <= t;
      delay <= 4'($urandom % 5);
      // The answer stands one cycle; a hit shows right after the taking edge
      for (i = 0; i < 40; i++)
      begin
         @(posedge mclk);
         if (i == 0) xl_req <= 1'b0;
         #1;
         f = f | xl_fetch;
         if (xl_hit === 1'b1) break;
      end
      `CHK(xl_hit, 1'b1)
      `CHK(xl_fetch, 1'b0)
      `CHK(f, !(reg_m[7] && cached.exists(int'(t))))
      if (ent_valid) `CHK(xl_pfn, t ^ 20'h5a5a5)
      if (reg_m[7] && ent_valid) cached[int'(t)] = 1'b1;
   endtask : xl

   // Rate field as software sees it, against random negotiated values
   task rate_chk;
      repeat (4)
      begin
         @(posedge mclk);
         rate_raw <= 3'($urandom);
         @(negedge mclk);
         `CHK(rate_read, reg_m[0] ? 3'h1 : rate_raw)
      end
   endtask : rate_chk

   task tally_and_finish;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(22655));
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      cfg(1'b0, 8'hb0, 32'h0, 0);
      cfg(1'b0, 8'hb4, 32'h0, 0);
      $display("test reset_values done");
      // Override goes in before any port traffic, as software must
      cfg(1'b1, 8'hb0, 32'hffff_ffff, 2);
      cfg(1'b0, 8'hb0, 32'h0, 0);
      rate_chk();
      for (k = 0; k < 6; k++) xl(20'h100 + 20'(k % 3));
      $display("test enabled_cache done");
      cfg(1'b1, 8'hb0, 32'h0, 3);
      rate_chk();
      for (k = 0; k < 4; k++) xl(20'h100 + 20'(k % 2));
      @(posedge mclk);
      ent_valid <= 1'b0;
      xl(20'h2aa);
      xl(20'h2aa);
      @(posedge mclk);
      ent_valid <= 1'b1;
      $display("test disabled_cache done");
      // Re-enable: entries cached before the disable must have been flushed
      cfg(1'b1, 8'hb0, 32'h0000_0080, 1);
      for (k = 0; k < 4; k++) xl(20'h100 + 20'(k % 2));
      $display("test reenable done");
      // Reset in mid-run must bring the register back to all zeros
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      reg_m = 32'h0;
      cached.delete();
      `CHK(cache_en, 1'b0)
      cfg(1'b0, 8'hb0, 32'h0, 0);
      rate_chk();
      $display("test midrun_reset done");
      tally_and_finish();
   end

   // Cut a hang short
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
endmodule : test_graphics_tlb_control
